// >>> include/dsbi_consts.svh
// Timing, width and depth constants for the converter input host
`ifndef DSBI_CONSTS_SVH
`define DSBI_CONSTS_SVH
`define DSBI_CLK_NS        50
`define DSBI_LCLK_HALF_NS  200
`define DSBI_STB_NS        40
`define DSBI_UPD_NS        100
`define DSBI_WORD_BITS     16
`define DSBI_BYTE_BITS     8
`define DSBI_FIFO_DEPTH    16
`define DSBI_CNT_BITS      8
`endif

// >>> include/dsbi_pkg.sv
// Types shared by the converter input host
`include "dsbi_consts.svh"
package dsbi_pkg;
  typedef logic [`DSBI_WORD_BITS-1:0] dsbi_word_t;
  typedef logic [`DSBI_BYTE_BITS-1:0] dsbi_byte_t;
  typedef logic [`DSBI_CNT_BITS-1:0]  dsbi_cnt_t;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SER_SHIFT,
    ST_SER_END,
    ST_SER_GAP,
    ST_BYTE_SET,
    ST_BYTE_STB,
    ST_BYTE_HOLD,
    ST_UPD,
    ST_CLR_SET,
    ST_CLR_STB,
    ST_CLR_HOLD
  } dsbi_state_t;
endpackage

// >>> design/dsbi_fifo.sv
// Word FIFO between the user port and the pin sequencer
`timescale 1ns/1ps
`default_nettype none
module dsbi_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          push;
  logic          pop;

  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem[rptr_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      // Registered ready, so a full FIFO back-pressures the source at once
      in_ready_o <= cnt_d != FULL;
      if (push) begin
        wptr_q <= (wptr_q == LAST) ? '0 : wptr_q + AW'(1);
      end
      if (pop) begin
        rptr_q <= (rptr_q == LAST) ? '0 : rptr_q + AW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_q] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// >>> design/dsbi_clkdiv.sv
// Divider that paces the load clock phases
`timescale 1ns/1ps
`default_nettype none
module dsbi_clkdiv #(
  parameter int HALF = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic run_i,
  output logic      fall_o,
  output logic      rise_o
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] TOP = CW'(HALF - 1);

  logic [CW-1:0] cnt_q;
  logic          phase_q;
  logic          wrap;

  assign wrap = run_i && (cnt_q == TOP);
  assign fall_o = ce_i && wrap && phase_q;
  assign rise_o = ce_i && wrap && !phase_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      phase_q <= 1'b1;
    end else if (ce_i) begin
      if (!run_i) begin
        cnt_q <= '0;
        phase_q <= 1'b1;
      end else if (wrap) begin
        cnt_q <= '0;
        phase_q <= !phase_q;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/dsbi_host.sv
// Host controller driving the serial/byte input pins of a 16-bit converter
`timescale 1ns/1ps
`default_nettype none
module dsbi_host
  import dsbi_pkg::*;
#(
  parameter int W      = `DSBI_WORD_BITS,
  parameter int DEPTH  = `DSBI_FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] word_i,
  input  wire logic         word_valid_i,
  output logic              word_ready_o,
  input  wire logic         byte_mode_i,
  input  wire logic         msb_first_i,
  input  wire logic         paced_i,
  input  wire logic         tick_i,
  input  wire logic         update_req_i,
  input  wire logic         clear_req_i,
  input  wire logic         clear_bipolar_i,
  output logic              busy_o,
  output logic [W-1:0]      chain_word_o,
  output logic              chain_valid_o,
  output logic              load_clk_o,
  output logic [7:0]        parallel_data_o,
  output logic              shift_mode_n_o,
  output logic              dac_update_o,
  output logic              async_clear_n_o,
  output logic              high_byte_load_n_o,
  output logic              low_byte_load_n_o,
  input  wire logic         serial_chain_out_i
);
  localparam int HALF_CYC =
    (`DSBI_LCLK_HALF_NS + `DSBI_CLK_NS - 1) / `DSBI_CLK_NS;
  localparam int STB_CYC = (`DSBI_STB_NS + `DSBI_CLK_NS - 1) / `DSBI_CLK_NS;
  localparam int UPD_CYC = (`DSBI_UPD_NS + `DSBI_CLK_NS - 1) / `DSBI_CLK_NS;
  localparam dsbi_cnt_t STB_LD = dsbi_cnt_t'(STB_CYC - 1);
  localparam dsbi_cnt_t UPD_LD = dsbi_cnt_t'(UPD_CYC - 1);
  localparam logic [4:0] LAST_BIT = 5'(W - 1);

  dsbi_state_t state_q;
  dsbi_cnt_t   cnt_q;
  logic [W-1:0] sr_q;
  logic [4:0]  bit_q;
  logic        msb_q;
  logic        hi_q;
  logic        bip_q;
  logic        ser_q;
  logic        chain_s1_q;
  logic        chain_s2_q;
  logic [W-1:0] chain_sr_q;
  logic        fall;
  logic        rise;
  logic        run;
  logic [W-1:0] fifo_word;
  logic        fifo_valid;
  logic        go;
  logic        idle_free;

  // Next bit to present on the serial pin for the chosen order
  function automatic logic pick_bit(input logic [W-1:0] sr, input logic msb);
    pick_bit = msb ? sr[W-1] : sr[0];
  endfunction

  function automatic logic [W-1:0] shift_on(input logic [W-1:0] sr, input logic msb);
    shift_on = msb ? {sr[W-2:0], 1'b0} : {1'b0, sr[W-1:1]};
  endfunction

  assign run = (state_q == ST_SER_SHIFT) || (state_q == ST_SER_END) ||
               (state_q == ST_SER_GAP);
  assign idle_free = ce_i && (state_q == ST_IDLE) && !clear_req_i && !update_req_i;
  // Timer pacing keeps sample jitter off the output
  assign go = idle_free && fifo_valid && (!paced_i || tick_i);

  dsbi_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   (word_i),
    .in_valid_i  (word_valid_i),
    .in_ready_o  (word_ready_o),
    .out_data_o  (fifo_word),
    .out_valid_o (fifo_valid),
    .out_ready_i (go)
  );

  dsbi_clkdiv #(
    .HALF (HALF_CYC)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .run_i  (run),
    .fall_o (fall),
    .rise_o (rise)
  );

  // Chain return crosses from the device, two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_s1_q <= 1'b0;
      chain_s2_q <= 1'b0;
    end else if (ce_i) begin
      chain_s1_q <= serial_chain_out_i;
      chain_s2_q <= chain_s1_q;
    end
  end

  // Chain bits sampled at each load clock fall, end of the high phase, well after the device edge settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_sr_q <= '0;
      chain_word_o <= '0;
      chain_valid_o <= 1'b0;
    end else if (ce_i) begin
      chain_valid_o <= 1'b0;
      if (fall && state_q == ST_SER_SHIFT) begin
        chain_sr_q <= msb_q ? {chain_sr_q[W-2:0], chain_s2_q}
                            : {chain_s2_q, chain_sr_q[W-1:1]};
      end
      if (fall && state_q == ST_SER_END) begin
        chain_word_o <= chain_sr_q;
        chain_valid_o <= 1'b1;
      end
    end
  end

  // Sequencer and pin drivers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      sr_q <= '0;
      bit_q <= '0;
      msb_q <= 1'b1;
      hi_q <= 1'b0;
      bip_q <= 1'b0;
      ser_q <= 1'b0;
      busy_o <= 1'b0;
      load_clk_o <= 1'b1;
      parallel_data_o <= 8'h00;
      shift_mode_n_o <= 1'b1;
      dac_update_o <= 1'b0;
      async_clear_n_o <= 1'b1;
      high_byte_load_n_o <= 1'b1;
      low_byte_load_n_o <= 1'b1;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE: begin
          busy_o <= 1'b0;
          if (clear_req_i) begin
            bip_q <= clear_bipolar_i;
            busy_o <= 1'b1;
            state_q <= ST_CLR_SET;
          end else if (update_req_i) begin
            busy_o <= 1'b1;
            dac_update_o <= 1'b1;
            cnt_q <= UPD_LD;
            state_q <= ST_UPD;
          end else if (go) begin
            busy_o <= 1'b1;
            sr_q <= fifo_word;
            msb_q <= msb_first_i;
            ser_q <= !byte_mode_i;
            bit_q <= '0;
            hi_q <= 1'b0;
            if (byte_mode_i) begin
              parallel_data_o <= fifo_word[7:0];
              state_q <= ST_BYTE_SET;
            end else begin
              parallel_data_o[1] <= msb_first_i;
              state_q <= ST_SER_SHIFT;
            end
          end
        end
        ST_SER_SHIFT: begin
          if (fall) begin
            // Data changes on the falling edge, stable at the rising one
            load_clk_o <= 1'b0;
            parallel_data_o[0] <= pick_bit(sr_q, msb_q);
            sr_q <= shift_on(sr_q, msb_q);
            shift_mode_n_o <= 1'b0;
          end
          if (rise) begin
            load_clk_o <= 1'b1;
            bit_q <= bit_q + 5'd1;
            if (bit_q == LAST_BIT) begin
              state_q <= ST_SER_END;
            end
          end
        end
        ST_SER_END: begin
          if (fall) begin
            shift_mode_n_o <= 1'b1;
            state_q <= ST_SER_GAP;
          end
        end
        ST_SER_GAP: begin
          if (fall) begin
            dac_update_o <= 1'b1;
            cnt_q <= UPD_LD;
            state_q <= ST_UPD;
          end
        end
        ST_BYTE_SET: begin
          // The hi_q flag picks which byte strobe fires
          low_byte_load_n_o <= hi_q;
          high_byte_load_n_o <= !hi_q;
          cnt_q <= STB_LD;
          state_q <= ST_BYTE_STB;
        end
        ST_BYTE_STB: begin
          if (cnt_q == '0) begin
            low_byte_load_n_o <= 1'b1;
            high_byte_load_n_o <= 1'b1;
            state_q <= ST_BYTE_HOLD;
          end else begin
            cnt_q <= cnt_q - dsbi_cnt_t'(1);
          end
        end
        ST_BYTE_HOLD: begin
          if (!hi_q) begin
            hi_q <= 1'b1;
            parallel_data_o <= sr_q[15:8];
            state_q <= ST_BYTE_SET;
          end else begin
            dac_update_o <= 1'b1;
            cnt_q <= UPD_LD;
            state_q <= ST_UPD;
          end
        end
        ST_UPD: begin
          if (cnt_q == '0) begin
            dac_update_o <= 1'b0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - dsbi_cnt_t'(1);
          end
        end
        ST_CLR_SET: begin
          // Polarity level settles one cycle before the clear falls
          low_byte_load_n_o <= bip_q;
          state_q <= ST_CLR_STB;
        end
        ST_CLR_STB: begin
          async_clear_n_o <= 1'b0;
          cnt_q <= STB_LD;
          state_q <= ST_CLR_HOLD;
        end
        ST_CLR_HOLD: begin
          if (cnt_q == '0) begin
            if (!async_clear_n_o) begin
              async_clear_n_o <= 1'b1;
            end else begin
              low_byte_load_n_o <= 1'b1;
              state_q <= ST_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - dsbi_cnt_t'(1);
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  // Helper counters for the checks below
  logic [5:0] edges_q;
  logic [7:0] gap_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edges_q <= '0;
      gap_q <= '0;
    end else begin
      if (!shift_mode_n_o && load_clk_o && !$past(load_clk_o)) begin
        edges_q <= edges_q + 6'd1;
      end else if (shift_mode_n_o && $past(shift_mode_n_o) && !dac_update_o) begin
        edges_q <= '0;
      end
      if (!shift_mode_n_o) begin
        gap_q <= '0;
      end else if (ce_i && gap_q != 8'hff) begin
        gap_q <= gap_q + 8'd1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  upd_low_frame_a: assert property (!shift_mode_n_o |-> !dac_update_o)
    else $error("update high inside serial frame");
  frame_len_a: assert property ($rose(shift_mode_n_o) |-> edges_q == 6'd16)
    else $error("frame did not hold sixteen load edges");
  data_stable_a: assert property ($rose(load_clk_o) |-> $stable(parallel_data_o))
    else $error("serial data changed at load clock rise");
  upd_gap_a: assert property ($rose(dac_update_o) && ser_q |-> gap_q >= 8'(HALF_CYC))
    else $error("update too soon after frame end");
  strobe_excl_a: assert property (high_byte_load_n_o || low_byte_load_n_o)
    else $error("both byte strobes active");
  clear_pol_a: assert property (!async_clear_n_o |-> low_byte_load_n_o == bip_q)
    else $error("clear polarity level wrong");
  upd_quiet_a: assert property ($rose(dac_update_o) |->
      high_byte_load_n_o && low_byte_load_n_o && async_clear_n_o)
    else $error("update overlaps a strobe");
  paced_go_a: assert property ($past(state_q) == ST_IDLE && $past(paced_i) &&
      state_q inside {ST_SER_SHIFT, ST_BYTE_SET} |-> $past(tick_i))
    else $error("paced transfer started without tick");
  bits_per_word_a: assert property ($rose(dac_update_o) && ser_q |->
      bit_q == 5'(W))
    else $error("update before all bits shifted");
  byte_order_a: assert property ($fell(high_byte_load_n_o) |->
      hi_q && parallel_data_o == sr_q[15:8])
    else $error("high byte strobe with wrong data");

  ser_word_c: cover property ($rose(dac_update_o) && ser_q);
  byte_word_c: cover property ($rose(dac_update_o) && !ser_q && busy_o);
  clear_bip_c: cover property ($fell(async_clear_n_o) && bip_q);
  fifo_full_c: cover property (!word_ready_o && word_valid_i);
endmodule
`default_nettype wire

// >>> tb/dsbi_dev_model.sv
// Behavioural model of the converter's digital input port
`timescale 1ns/1ps
`default_nettype none
module dsbi_dev_model #(
  parameter logic [15:0] UNI_ZERO = 16'h0000,
  parameter logic [15:0] BIP_ZERO = 16'h8000
) (
  input  wire logic       load_clk_i,
  input  wire logic [7:0] parallel_data_i,
  input  wire logic       shift_mode_n_i,
  input  wire logic       dac_update_i,
  input  wire logic       async_clear_n_i,
  input  wire logic       high_byte_load_n_i,
  input  wire logic       low_byte_load_n_i,
  output logic            serial_chain_out_o,
  output logic [15:0]     first_rank_o,
  output logic [15:0]     dac_latch_o
);
  logic [15:0] first_q = 16'h0000;
  logic [15:0] dac_q;
  logic        lclk_prev = 1'b1;
  // One process owns the first rank; shift on load clock rise, bit 1 sets direction
  always @(load_clk_i or parallel_data_i or shift_mode_n_i or high_byte_load_n_i or
           low_byte_load_n_i) begin
    if (load_clk_i === 1'b1 && lclk_prev !== 1'b1 && !shift_mode_n_i) begin
      if (parallel_data_i[1]) first_q = {first_q[14:0], parallel_data_i[0]};
      else first_q = {parallel_data_i[0], first_q[15:1]};
    end
    lclk_prev = load_clk_i;
    // Level gated halves, either order
    if (shift_mode_n_i) begin
      if (!low_byte_load_n_i) first_q[7:0] = parallel_data_i;
      if (!high_byte_load_n_i) first_q[15:8] = parallel_data_i;
    end
  end
  // Oldest bit sits at the end the shift moves toward
  assign serial_chain_out_o = parallel_data_i[1] ? first_q[15] : first_q[0];
  // Clear touches only the second rank; otherwise it holds
  always @* begin
    if (!async_clear_n_i) dac_q = low_byte_load_n_i ? BIP_ZERO : UNI_ZERO;
    else if (dac_update_i) dac_q = first_q;
  end
  assign first_rank_o = first_q;
  assign dac_latch_o  = dac_q;
endmodule
`default_nettype wire

// >>> tb/dsbi_host_tb_top.sv
// Self-checking bench for the converter input host
`timescale 1ns/1ps
`default_nettype none
module dsbi_host_tb_top;
  import dsbi_pkg::*;
  localparam int DEPTH = 16;
  logic clk_i = 0, rst_i = 1, ce_i = 1, word_valid_i = 0, byte_mode_i = 0;
  logic msb_first_i = 0, paced_i = 0, tick_i = 0, update_req_i = 0;
  logic clear_req_i = 0, clear_bipolar_i = 0;
  dsbi_word_t word_i = '0;
  logic word_ready_o, busy_o, chain_valid_o, load_clk, shift_mode_n, dac_update;
  logic clear_n, hb_load_n, lb_load_n, chain_out;
  logic [7:0] pdata;
  dsbi_word_t chain_word_o, first_rank, dac_latch, pre_frame, keep, w;
  dsbi_word_t exp_q[$];
  int mismatches = 0, n_checks = 0, cyc = 0, rises = 0, n;
  always #25 clk_i = ~clk_i;
  dsbi_host #(.W(16), .DEPTH(DEPTH)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .word_i(word_i),
    .word_valid_i(word_valid_i), .word_ready_o(word_ready_o),
    .byte_mode_i(byte_mode_i), .msb_first_i(msb_first_i), .paced_i(paced_i),
    .tick_i(tick_i), .update_req_i(update_req_i), .clear_req_i(clear_req_i),
    .clear_bipolar_i(clear_bipolar_i), .busy_o(busy_o), .chain_word_o(chain_word_o),
    .chain_valid_o(chain_valid_o), .load_clk_o(load_clk), .parallel_data_o(pdata),
    .shift_mode_n_o(shift_mode_n), .dac_update_o(dac_update),
    .async_clear_n_o(clear_n), .high_byte_load_n_o(hb_load_n),
    .low_byte_load_n_o(lb_load_n), .serial_chain_out_i(chain_out));
  dsbi_dev_model dev (
    .load_clk_i(load_clk), .parallel_data_i(pdata), .shift_mode_n_i(shift_mode_n),
    .dac_update_i(dac_update), .async_clear_n_i(clear_n),
    .high_byte_load_n_i(hb_load_n), .low_byte_load_n_i(lb_load_n),
    .serial_chain_out_o(chain_out), .first_rank_o(first_rank), .dac_latch_o(dac_latch));
  function automatic dsbi_word_t zero_val(input logic bip);
    return bip ? 16'h8000 : 16'h0000;
  endfunction
  task automatic chk(input dsbi_word_t got, input dsbi_word_t exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d n_checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Leaves valid high so back-to-back words need no gap
  task automatic push(input dsbi_word_t v);
    int k = 0;
    word_i = v;
    word_valid_i = 1;
    while (word_ready_o !== 1'b1 && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
    exp_q.push_back(v);
  endtask
  task automatic wait_idle;
    int k = 0;
    repeat (4) @(negedge clk_i);
    while (busy_o !== 1'b0 && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic cmd(input logic clr, input logic bip);
    clear_req_i = clr;
    update_req_i = !clr;
    clear_bipolar_i = bip;
    @(negedge clk_i);
    clear_req_i = 0;
    update_req_i = 0;
    wait_idle();
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("BAD %0t run did not finish", $time);
      wrap_up();
    end
    if (!rst_i && hb_load_n === 1'b0 && lb_load_n === 1'b0) chk(16'h1, 16'h0, "both strobes");
    if (chain_valid_o === 1'b1) chk(chain_word_o, pre_frame, "chain word");
  end
  // Every update must move the expected word into the second rank
  always @(negedge dac_update) begin
    if (!rst_i) begin
      if (exp_q.size() > 0) chk(dac_latch, exp_q.pop_front(), "update value");
      else chk(16'h1, 16'h0, "stray update");
    end
  end
  always @(negedge shift_mode_n) pre_frame = first_rank;
  always @(posedge load_clk) if (!shift_mode_n) rises++;
  always @(posedge shift_mode_n) begin
    if (!rst_i) chk(16'(rises), 16'd16, "frame edges");
    rises = 0;
  end
  initial begin
    void'($urandom(59157));
    repeat (20) @(negedge clk_i);
    rst_i = 0;
    // Serial words, both orders, with all-ones and single-bit corners
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0001 : 16'($urandom);
      msb_first_i = i[0];
      push(w);
      word_valid_i = 0;
      // Clock enable low mid-frame must freeze the pins and the sequence
      if (i == 3) begin
        repeat (40) @(negedge clk_i);
        ce_i = 0;
        keep = {6'h0, busy_o, load_clk, pdata};
        repeat (7) @(negedge clk_i);
        chk({6'h0, busy_o, load_clk, pdata}, keep, "frozen pins");
        ce_i = 1;
      end
      wait_idle();
      chk(first_rank, w, "serial load");
    end
    byte_mode_i = 1;
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 16'h00ff : 16'($urandom);
      push(w);
      word_valid_i = 0;
      wait_idle();
      chk(first_rank, w, "byte load");
    end
    keep = first_rank;
    cmd(1, 1);
    chk(dac_latch, zero_val(1), "bipolar clear");
    chk(first_rank, keep, "rank kept");
    exp_q.push_back(keep);
    cmd(0, 0);
    cmd(1, 0);
    chk(dac_latch, zero_val(0), "unipolar clear");
    chk({first_rank[15:8], 8'h00}, {keep[15:8], 8'h00}, "high kept");
    // Paced: the queue fills while no tick arrives, then drains
    byte_mode_i = 0;
    paced_i = 1;
    n = 0;
    while (word_ready_o === 1'b1 && n < 20) begin
      push(16'($urandom));
      n++;
    end
    word_valid_i = 0;
    chk(16'(n), 16'(DEPTH), "fifo depth");
    repeat (10) @(negedge clk_i);
    chk({15'h0, busy_o}, 16'h0, "start without tick");
    repeat (DEPTH) begin
      tick_i = 1;
      @(negedge clk_i);
      tick_i = 0;
      repeat (299) @(negedge clk_i);
    end
    wait_idle();
    chk(16'(exp_q.size()), 16'h0, "queue drained");
    wrap_up();
  end
endmodule
`default_nettype wire
